/* rtl/cdu_cmd_regs.sv */
// Upper command register bank: decodes commands, drives pin controls.
// Assumes serial lines and pin sources synchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none
module cdu_cmd_regs #(
  parameter int BITS = cdu_pkg::FRAME_BITS
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Serial control
  input wire logic ctrl_serial_clock,
  input wire logic ctrl_serial_data,
  input wire logic ctrl_serial_enable,
  input wire logic ctrl_data_src,
  output logic ctrl_data_out,
  output logic ctrl_data_oe,
  // Sources from the decoder core
  input wire logic audio_before,
  input wire logic audio_after,
  input wire logic misc_src,
  input wire logic sclk_src,
  input wire logic wclk_src,
  input wire logic data_src,
  input wire logic div_clk_src,
  input wire logic kill_left,
  input wire logic kill_right,
  input wire logic kill_both,
  input wire logic subcode_src,
  input wire logic deemph_src,
  input wire logic motor_a_src,
  input wire logic motor_b_src,
  input wire logic motor_a_oe_src,
  input wire logic motor_b_oe_src,
  input wire logic pulse_density_mode,
  input wire logic motor4_a,
  input wire logic motor4_b,
  input wire logic multipin_one_in,
  // Settings to the core
  output logic [3:0] loop_bw_code,
  output logic [3:0] loop_eq_code,
  output logic [1:0] audio_src_sel,
  output logic clock_level_three,
  output logic flags_in_audio,
  output logic double_speed,
  output logic half_crystal,
  output logic stop_standby,
  output logic pause_standby,
  output logic offtrack_enable,
  output logic offtrack_in,
  output logic multipin_one_status,
  output logic four_line_motor,
  // Pins
  output logic biphase_audio_out,
  output logic biphase_audio_oe,
  output logic misc_out,
  output logic sclk_out,
  output logic wclk_out,
  output logic data_out,
  output logic audio_ser_oe,
  output logic divided_clock_out,
  output logic divided_clock_oe,
  output logic kill_out,
  output logic multipin_three,
  output logic multipin_four,
  output logic multipin_five,
  output logic motor_out_a,
  output logic motor_out_a_oe,
  output logic motor_out_b,
  output logic motor_out_b_oe
);

  typedef struct packed {
    logic [3:0] loop_bw;
    logic [3:0] loop_eq;
    logic [1:0] audio_src;
    logic accuracy;
    logic flags;
    logic dspeed;
    logic xtal;
    cdu_pkg::cdu_state_e state;
    logic offtrack;
    logic single_kill;
    logic pin3;
    logic motor4;
    logic [1:0] pin4;
    logic [1:0] pin5;
    logic [4:0] pins_o;
  } cdu_regs_s;

  cdu_regs_s r;
  cdu_regs_s next_r;
  logic cmd_valid;
  logic [3:0] cmd_addr;
  logic [3:0] cmd_data;

  // ==========================================
  // Parameter check
  if (BITS != cdu_pkg::FRAME_BITS)
  begin : g_bits_check
    $error("cdu_cmd_regs supports 8-bit frames only");
  end

  // ==========================================
  // Serial receiver
  cdu_serial_rx #(
    .BITS(BITS)
  ) u_rx (
    .ref_clk(ref_clk),
    .srst(srst),
    .ctrl_serial_clock(ctrl_serial_clock),
    .ctrl_serial_data(ctrl_serial_data),
    .ctrl_serial_enable(ctrl_serial_enable),
    .cmd_valid(cmd_valid),
    .cmd_addr(cmd_addr),
    .cmd_data(cmd_data)
  );

  // ==========================================
  // Helper functions
  // Level or alternate source of a multipurpose pin
  function automatic logic pin_level(input logic [1:0] sel, input logic alt, input logic cur);
    case (sel)
      cdu_pkg::PIN_ALT: pin_level = alt;
      cdu_pkg::PIN_ZERO: pin_level = 1'b0;
      cdu_pkg::PIN_ONE: pin_level = 1'b1;
      default: pin_level = cur;
    endcase
  endfunction

  // Valid loop bandwidth code: bits 1 and 0 not both set
  function automatic logic bw_ok(input logic [3:0] c);
    bw_ok = !(c[1] && c[0]);
  endfunction

  // ==========================================
  // Command decode
  always_comb
  begin
    next_r = r;
    if (cmd_valid)
    begin
      case (cmd_addr)
        cdu_pkg::ADDR_LOOP_BW:
        begin
          if (bw_ok(cmd_data))
          begin
            next_r.loop_bw = cmd_data;
          end
        end
        cdu_pkg::ADDR_LOOP_EQ:
        begin
          if (cmd_data >= cdu_pkg::EQ_MIN && cmd_data <= cdu_pkg::EQ_MAX)
          begin
            next_r.loop_eq = cmd_data;
          end
        end
        cdu_pkg::ADDR_AUDIO_OUT:
        begin
          if (cmd_data[1:0] != 2'h1)
          begin
            next_r.audio_src = cmd_data[1:0];
          end
          next_r.accuracy = cmd_data[2];
          next_r.flags = cmd_data[3];
        end
        cdu_pkg::ADDR_SPEED:
        begin
          next_r.dspeed = cmd_data[3];
          next_r.xtal = cmd_data[2];
          case (cmd_data[1:0])
            cdu_pkg::ST_STOP: next_r.state = cdu_pkg::CDU_STOP;
            cdu_pkg::ST_PAUSE: next_r.state = cdu_pkg::CDU_PAUSE;
            cdu_pkg::ST_RUN: next_r.state = cdu_pkg::CDU_RUN;
            default: next_r.state = r.state;
          endcase
        end
        cdu_pkg::ADDR_PINS_A:
        begin
          next_r.offtrack = cmd_data[0];
          next_r.single_kill = cmd_data[1];
          if (cmd_data[1])
          begin
            next_r.pin3 = cmd_data[2];
          end
        end
        cdu_pkg::ADDR_PINS_B:
        begin
          if (cmd_data == cdu_pkg::CODE_MOTOR4)
          begin
            next_r.motor4 = 1'b1;
          end
          else
          begin
            next_r.motor4 = 1'b0;
            if (cmd_data[1:0] != 2'h0)
            begin
              next_r.pin4 = cmd_data[1:0];
            end
            if (cmd_data[3:2] != 2'h0)
            begin
              next_r.pin5 = cmd_data[3:2];
            end
          end
        end
        default:
        begin
          next_r = r;
        end
      endcase
    end
    next_r.pins_o[0] = r.single_kill ? kill_both : kill_left;
    next_r.pins_o[1] = r.single_kill ? r.pin3 : kill_right;
    next_r.pins_o[2] = r.motor4 ? motor4_a : pin_level(r.pin4, subcode_src, r.pins_o[2]);
    next_r.pins_o[3] = r.motor4 ? motor4_b : pin_level(r.pin5, deemph_src, r.pins_o[3]);
    next_r.pins_o[4] = (r.audio_src == cdu_pkg::SRC_BEFORE) ? audio_before : audio_after;
  end

  // ==========================================
  // Register update
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      r <= '0;
      r.loop_bw <= cdu_pkg::RST_LOOP_BW;
      r.loop_eq <= cdu_pkg::RST_LOOP_EQ;
      r.audio_src <= cdu_pkg::RST_AUDIO_SRC;
      r.state <= cdu_pkg::CDU_STOP;
      r.single_kill <= cdu_pkg::RST_SINGLE_KILL;
      r.pin4 <= cdu_pkg::RST_PIN_LEVEL;
      r.pin5 <= cdu_pkg::RST_PIN_LEVEL;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ==========================================
  // Settings
  assign loop_bw_code = r.loop_bw;
  assign loop_eq_code = r.loop_eq;
  assign audio_src_sel = r.audio_src;
  assign clock_level_three = r.accuracy;
  assign flags_in_audio = r.flags;
  assign double_speed = r.dspeed;
  assign half_crystal = r.xtal;
  assign stop_standby = (r.state == cdu_pkg::CDU_STOP);
  assign pause_standby = (r.state == cdu_pkg::CDU_PAUSE);
  assign offtrack_enable = r.offtrack;
  assign offtrack_in = r.offtrack & multipin_one_in;
  assign multipin_one_status = r.offtrack ? 1'b0 : multipin_one_in;
  assign four_line_motor = r.motor4;

  // ==========================================
  // Pin drivers
  logic standby;
  assign standby = stop_standby | pause_standby;

  assign ctrl_data_out = ctrl_data_src;
  assign ctrl_data_oe = ctrl_serial_enable;

  assign audio_ser_oe = !standby;
  assign misc_out = misc_src;
  assign sclk_out = sclk_src;
  assign wclk_out = wclk_src;
  assign data_out = data_src;
  assign divided_clock_out = div_clk_src;
  assign divided_clock_oe = !standby;
  assign biphase_audio_oe = !standby;
  assign biphase_audio_out = (r.audio_src == cdu_pkg::SRC_LOW) ? 1'b0 : r.pins_o[4];

  // ==========================================
  // Multipurpose pins
  assign kill_out = r.pins_o[0];
  assign multipin_three = r.pins_o[1];
  assign multipin_four = r.pins_o[2];
  assign multipin_five = r.pins_o[3];

  // ==========================================
  // Motor pins
  // Motor pins in stop standby
  always_comb
  begin
    motor_out_a = motor_a_src;
    motor_out_b = motor_b_src;
    motor_out_a_oe = motor_a_oe_src;
    motor_out_b_oe = motor_b_oe_src;
    if (stop_standby)
    begin
      motor_out_a = 1'b0;
      motor_out_b = 1'b0;
      motor_out_a_oe = !pulse_density_mode;
      motor_out_b_oe = !pulse_density_mode;
    end
  end

endmodule
`default_nettype wire

/* rtl/cdu_pkg.sv */
// Package for the upper command register bank of the disc decoder.
// Assumes a 4-bit address and 4-bit data command written per transfer.
package cdu_pkg;

  // ==========================================
  // Command addresses
  localparam logic [3:0] ADDR_LOOP_BW = 4'h8;
  localparam logic [3:0] ADDR_LOOP_EQ = 4'h9;
  localparam logic [3:0] ADDR_AUDIO_OUT = 4'ha;
  localparam logic [3:0] ADDR_SPEED = 4'hb;
  localparam logic [3:0] ADDR_PINS_A = 4'hc;
  localparam logic [3:0] ADDR_PINS_B = 4'hd;

  // ==========================================
  // Reset values
  localparam logic [3:0] RST_LOOP_BW = 4'h9;
  localparam logic [3:0] RST_LOOP_EQ = 4'h3;
  localparam logic [1:0] RST_AUDIO_SRC = 2'h2;
  localparam logic [1:0] RST_OP_STATE = 2'h0;
  localparam logic [1:0] RST_PIN_LEVEL = 2'h3;
  localparam logic RST_SINGLE_KILL = 1'h1;

  // ==========================================
  // Field codes
  localparam logic [1:0] SRC_BEFORE = 2'h0;
  localparam logic [1:0] SRC_AFTER = 2'h2;
  localparam logic [1:0] SRC_LOW = 2'h3;
  localparam logic [1:0] ST_STOP = 2'h0;
  localparam logic [1:0] ST_PAUSE = 2'h2;
  localparam logic [1:0] ST_RUN = 2'h3;
  localparam logic [1:0] PIN_ALT = 2'h1;
  localparam logic [1:0] PIN_ZERO = 2'h2;
  localparam logic [1:0] PIN_ONE = 2'h3;
  localparam logic [3:0] CODE_MOTOR4 = 4'h0;
  localparam logic [3:0] EQ_MIN = 4'h1;
  localparam logic [3:0] EQ_MAX = 4'h5;

  // ==========================================
  // Serial frame
  localparam int FRAME_BITS = 8;

  // ==========================================
  // Operating states: run and the two standby states
  typedef enum logic [1:0] {CDU_RUN, CDU_PAUSE, CDU_STOP} cdu_state_e;

endpackage

/* rtl/cdu_serial_rx.sv */
// Serial command receiver: shifts 8 bits, address first, MSB first.
// Assumes serial lines synchronous to ref_clk; enable high frames a write.
`timescale 1ns/100ps
`default_nettype none
module cdu_serial_rx #(
  parameter int BITS = cdu_pkg::FRAME_BITS
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Serial lines
  input wire logic ctrl_serial_clock,
  input wire logic ctrl_serial_data,
  input wire logic ctrl_serial_enable,
  // Received command
  output logic cmd_valid,
  output logic [3:0] cmd_addr,
  output logic [3:0] cmd_data
);

  if (BITS != cdu_pkg::FRAME_BITS)
  begin : g_bits_check
    $error("cdu_serial_rx supports 8-bit frames only");
  end

  localparam logic [3:0] LAST_CNT = 4'(BITS);

  typedef struct packed {
    logic clk_d;
    logic en_d;
    logic [7:0] shift;
    logic [3:0] cnt;
    logic valid;
    logic [3:0] addr;
    logic [3:0] data;
  } cdu_rx_s;

  cdu_rx_s st;
  cdu_rx_s next_st;

  // ==========================================
  // Shift and frame end
  always_comb
  begin
    next_st = st;
    next_st.clk_d = ctrl_serial_clock;
    next_st.en_d = ctrl_serial_enable;
    next_st.valid = 1'b0;
    if (ctrl_serial_enable && ctrl_serial_clock && !st.clk_d && st.cnt < LAST_CNT)
    begin
      next_st.shift = {st.shift[6:0], ctrl_serial_data};
      next_st.cnt = st.cnt + 4'h1;
    end
    if (!ctrl_serial_enable)
    begin
      next_st.cnt = 4'h0;
    end
    if (st.en_d && !ctrl_serial_enable && st.cnt == LAST_CNT)
    begin
      next_st.valid = 1'b1;
      next_st.addr = st.shift[7:4];
      next_st.data = st.shift[3:0];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign cmd_valid = st.valid;
  assign cmd_addr = st.addr;
  assign cmd_data = st.data;

endmodule
`default_nettype wire

/* verification/cdu_cmd_regs_chk.sv */
// Checker for the upper command register bank.
// Assumes binding to cdu_cmd_regs; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module cdu_cmd_regs_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Inputs watched
  input wire logic ctrl_serial_enable,
  input wire logic multipin_one_in,
  input wire logic pulse_density_mode,
  input wire logic motor_a_src,
  input wire logic motor_a_oe_src,
  // Outputs watched
  input wire logic ctrl_data_oe,
  input wire logic [3:0] loop_bw_code,
  input wire logic [1:0] audio_src_sel,
  input wire logic stop_standby,
  input wire logic pause_standby,
  input wire logic offtrack_enable,
  input wire logic offtrack_in,
  input wire logic biphase_audio_out,
  input wire logic biphase_audio_oe,
  input wire logic audio_ser_oe,
  input wire logic divided_clock_oe,
  input wire logic motor_out_a,
  input wire logic motor_out_a_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // ==========================================
  // Assertions
  a_data_oe_follow: assert property (ctrl_data_oe == ctrl_serial_enable)
    else $error("data output enable not tied to frame enable");
  a_standby_floats: assert property ((stop_standby || pause_standby) |->
    !audio_ser_oe && !divided_clock_oe && !biphase_audio_oe)
    else $error("audio outputs driven in standby");
  a_run_drives: assert property (!stop_standby && !pause_standby |->
    audio_ser_oe && divided_clock_oe && biphase_audio_oe)
    else $error("audio outputs floating while running");
  a_stop_motor: assert property (stop_standby |->
    !motor_out_a && (motor_out_a_oe == !pulse_density_mode))
    else $error("motor pin wrong in stop standby");
  a_pause_motor: assert property (pause_standby |->
    motor_out_a == motor_a_src && motor_out_a_oe == motor_a_oe_src)
    else $error("motor pin not passed through in pause");
  a_state_single: assert property (!(stop_standby && pause_standby))
    else $error("both standby states at once");
  a_audio_low: assert property (audio_src_sel == cdu_pkg::SRC_LOW |-> !biphase_audio_out)
    else $error("digital audio pin not held low");
  a_offtrack_pin: assert property (offtrack_in == (offtrack_enable && multipin_one_in))
    else $error("off-track input not gated by its enable");
  a_settings_hold: assert property (!ctrl_serial_enable [*4] |=>
    $stable(loop_bw_code) && $stable(audio_src_sel))
    else $error("setting changed without a frame");
  a_reset_defaults: assert property ($fell(srst) |->
    loop_bw_code == cdu_pkg::RST_LOOP_BW && audio_src_sel == cdu_pkg::RST_AUDIO_SRC
    && stop_standby && !offtrack_enable)
    else $error("defaults missing after reset");
  // ==========================================
  // Covers
  c_pause: cover property (pause_standby);
  c_run: cover property (!stop_standby && !pause_standby);
  c_audio_low: cover property (audio_src_sel == cdu_pkg::SRC_LOW);
endmodule
bind cdu_cmd_regs cdu_cmd_regs_chk u_cdu_cmd_regs_chk (.*);
`default_nettype wire

/* verification/cdu_mcu_model.sv */
// Microcontroller model: sends 8-bit command frames on the serial lines.
// Assumes serial phases of two ref_clk cycles, driven at falling edge.
`timescale 1ns/100ps
`default_nettype none
module cdu_mcu_model (
  // Clock
  input wire logic ref_clk,
  // Serial lines
  output logic ctrl_serial_clock,
  output logic ctrl_serial_data,
  output logic ctrl_serial_enable
);
  initial
  begin
    ctrl_serial_clock = 1'b0;
    ctrl_serial_data = 1'b1;
    ctrl_serial_enable = 1'b0;
  end
  // ==========================================
  // Frame send: address then data, MSB first
  task automatic send(input logic [3:0] addr, input logic [3:0] data);
    logic [7:0] frame;
    frame = {addr, data};
    @(negedge ref_clk);
    ctrl_serial_enable = 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      ctrl_serial_data = frame[i];
      repeat (2) @(negedge ref_clk);
      ctrl_serial_clock = 1'b1;
      repeat (2) @(negedge ref_clk);
      ctrl_serial_clock = 1'b0;
    end
    repeat (2) @(negedge ref_clk);
    ctrl_serial_enable = 1'b0;
    ctrl_serial_data = ~frame[0];
  endtask
endmodule
`default_nettype wire

/* verification/tb_cdu_cmd_regs.sv */
// Testbench for the upper command register bank.
// Assumes the microcontroller model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module tb_cdu_cmd_regs;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic ctrl_serial_clock, ctrl_serial_data, ctrl_serial_enable;
  logic ctrl_data_src, ctrl_data_out, ctrl_data_oe;
  logic audio_before, audio_after, misc_src, sclk_src, wclk_src, data_src, div_clk_src;
  logic kill_left, kill_right, kill_both, subcode_src, deemph_src;
  logic motor_a_src, motor_b_src, motor_a_oe_src, motor_b_oe_src, pulse_density_mode;
  logic motor4_a, motor4_b, multipin_one_in;
  logic [3:0] loop_bw_code, loop_eq_code;
  logic [1:0] audio_src_sel;
  logic clock_level_three, flags_in_audio, double_speed, half_crystal;
  logic stop_standby, pause_standby, offtrack_enable, offtrack_in;
  logic multipin_one_status, four_line_motor, biphase_audio_out, biphase_audio_oe;
  logic misc_out, sclk_out, wclk_out, data_out, audio_ser_oe;
  logic divided_clock_out, divided_clock_oe, kill_out;
  logic multipin_three, multipin_four, multipin_five;
  logic motor_out_a, motor_out_a_oe, motor_out_b, motor_out_b_oe;
  int mismatches = 0;
  int tests_run = 0;
  always #5 ref_clk = ~ref_clk;
  cdu_cmd_regs u_cdu_cmd_regs (.*);
  cdu_mcu_model u_cdu_mcu_model (.ref_clk, .ctrl_serial_clock, .ctrl_serial_data,
    .ctrl_serial_enable);
  // ==========================================
  // Tasks
  task automatic chk(input string name, input logic [3:0] seen, input logic [3:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    u_cdu_mcu_model.send(a, d);
    repeat (4) @(negedge ref_clk);
  endtask
  task end_sim;
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    end_sim;
  end
  // ==========================================
  // Main sequence
  initial
  begin
    {audio_before, audio_after, misc_src, sclk_src, wclk_src, data_src, div_clk_src,
      kill_left, kill_right, kill_both, subcode_src, deemph_src, motor_a_src, motor_b_src,
      motor_a_oe_src, motor_b_oe_src, pulse_density_mode, motor4_a, motor4_b,
      multipin_one_in, ctrl_data_src} = 21'h15_4936;
    repeat (3) @(negedge ref_clk);
    srst = 1'b0;
    @(negedge ref_clk);
    chk("loop_bw", loop_bw_code, cdu_pkg::RST_LOOP_BW);
    chk("loop_eq", loop_eq_code, cdu_pkg::RST_LOOP_EQ);
    chk("audio", {flags_in_audio, clock_level_three, audio_src_sel}, 4'h2);
    chk("speed", {double_speed, half_crystal, stop_standby, pause_standby}, 4'h2);
    chk("pins", {four_line_motor, multipin_five, multipin_four}, 4'h3);
    chk("pin_one", {offtrack_enable, multipin_one_status}, 4'h1);
    chk("kill_dflt", {multipin_three, kill_out}, {2'b00, 1'b0, kill_both});
    chk("data_oe", {ctrl_data_oe, ctrl_data_out}, {3'b000, ctrl_data_src});
    $display("Test defaults done");
    wr(cdu_pkg::ADDR_LOOP_BW, 4'h6);
    chk("loop_bw", loop_bw_code, 4'h6);
    wr(cdu_pkg::ADDR_LOOP_BW, 4'h3);
    chk("loop_bw_bad", loop_bw_code, 4'h6);
    for (int c = 1; c <= 5; c++)
    begin
      wr(cdu_pkg::ADDR_LOOP_EQ, 4'(c));
      chk("loop_eq", loop_eq_code, 4'(c));
    end
    wr(cdu_pkg::ADDR_LOOP_EQ, 4'h6);
    chk("loop_eq_bad", loop_eq_code, cdu_pkg::EQ_MAX);
    $display("Test loop done");
    wr(cdu_pkg::ADDR_AUDIO_OUT, 4'hf);
    chk("audio_bits", {flags_in_audio, clock_level_three, audio_src_sel}, 4'hf);
    chk("audio_pin", biphase_audio_out, 4'h0);
    wr(cdu_pkg::ADDR_AUDIO_OUT, 4'h1);
    chk("audio_bad", {flags_in_audio, clock_level_three, audio_src_sel}, 4'h3);
    wr(cdu_pkg::ADDR_AUDIO_OUT, 4'h0);
    chk("audio_src", audio_src_sel, cdu_pkg::SRC_BEFORE);
    $display("Test audio done");
    wr(cdu_pkg::ADDR_SPEED, 4'he);
    chk("pause", {double_speed, half_crystal, stop_standby, pause_standby}, 4'hd);
    chk("pause_oe", {audio_ser_oe, divided_clock_oe, biphase_audio_oe}, 4'h0);
    chk("pause_motor", {motor_out_a, motor_out_a_oe}, {2'b00, motor_a_src, motor_a_oe_src});
    wr(cdu_pkg::ADDR_SPEED, 4'h3);
    chk("run", {double_speed, half_crystal, stop_standby, pause_standby}, 4'h0);
    chk("run_oe", {audio_ser_oe, divided_clock_oe, biphase_audio_oe}, 4'h7);
    chk("run_pass", {misc_out, divided_clock_out}, {2'b00, misc_src, div_clk_src});
    chk("run_ser", {sclk_out, wclk_out, data_out}, 4'h2);
    wr(cdu_pkg::ADDR_SPEED, 4'h1);
    chk("state_bad", {stop_standby, pause_standby, audio_ser_oe}, 4'h1);
    wr(cdu_pkg::ADDR_SPEED, 4'h0);
    chk("stop_pdm", {motor_out_a, motor_out_a_oe}, 4'h0);
    pulse_density_mode = 1'b0;
    @(negedge ref_clk);
    chk("stop_pwm", {motor_out_a, motor_out_a_oe}, 4'h1);
    chk("stop_pwm_b", {motor_out_b, motor_out_b_oe}, 4'h1);
    $display("Test standby done");
    wr(cdu_pkg::ADDR_PINS_A, 4'h1);
    chk("offtrack", {offtrack_enable, offtrack_in, multipin_one_status}, 4'h6);
    wr(cdu_pkg::ADDR_PINS_A, 4'h6);
    chk("pin3_one", {multipin_three, kill_out}, {2'b00, 1'b1, kill_both});
    wr(cdu_pkg::ADDR_PINS_A, 4'h0);
    chk("kill_split", {multipin_three, kill_out}, {2'b00, kill_right, kill_left});
    wr(cdu_pkg::ADDR_PINS_B, 4'h5);
    chk("pins_src", {multipin_five, multipin_four}, 4'h0);
    {subcode_src, deemph_src} = 2'b11;
    repeat (2) @(negedge ref_clk);
    chk("pins_follow", {multipin_five, multipin_four}, 4'h3);
    wr(cdu_pkg::ADDR_PINS_B, 4'ha);
    chk("pins_zero", {multipin_five, multipin_four}, 4'h0);
    wr(cdu_pkg::ADDR_PINS_B, 4'h0);
    chk("motor4", {four_line_motor, multipin_five, multipin_four}, 4'h6);
    wr(cdu_pkg::ADDR_PINS_B, 4'h4);
    chk("pins_bad", {four_line_motor, multipin_five, multipin_four}, 4'h2);
    $display("Test pins done");
    end_sim;
  end
endmodule
`default_nettype wire
